// File: include/vism_pkg.sv
`default_nettype none
package vism_pkg;

  // Flag bytes packed four to a word, byte k at bits 8k+7..8k
  localparam int unsigned FLAG_W = 32;
  localparam int unsigned POS_W = 5;
  localparam int unsigned VEC_W = 16;
  localparam int unsigned PIN_N = 9;

  // Bit positions of each source inside the packed flag word
  localparam int unsigned POS_LVI = 0;
  localparam int unsigned POS_EXT0 = 1;
  localparam int unsigned POS_SERB_ERR = 7;
  localparam int unsigned POS_SERB_RX = 8;
  localparam int unsigned POS_SERB_TX = 9;
  localparam int unsigned POS_SHARED = 10;
  localparam int unsigned POS_TMH_SECOND = 11;
  localparam int unsigned POS_TMH_FIRST = 12;
  localparam int unsigned POS_T8A = 13;
  localparam int unsigned POS_T16A = 14;
  localparam int unsigned POS_T16B = 15;
  localparam int unsigned POS_CONV = 16;
  localparam int unsigned POS_SERA_RX = 17;
  localparam int unsigned POS_T8B = 19;
  localparam int unsigned POS_TWO_WIRE = 24;

  // Implemented flag bits; all others read as zero in request bytes
  localparam logic [31:0] FLAG_MAP = 32'h010B_FFFF;

  // Reset values of the flag groups
  localparam logic [31:0] REQ_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'hFFFF_FFFF;
  localparam logic [31:0] PRIO_RESET = 32'hFFFF_FFFF;

  // Mode-select bit inside the low-voltage control byte
  localparam int unsigned LVI_MODE_BIT = 1;

  // Pin synchroniser lanes: six external pins, two capture pins, reset
  localparam int unsigned PIN_CAP_A = 6;
  localparam int unsigned PIN_CAP_B = 7;
  localparam int unsigned PIN_RESET = 8;
  localparam logic [8:0] PIN_IDLE = 9'h100;

  // Fixed vectors outside the maskable table
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_BREAK = 16'h003E;

  // Which flag group a software write addresses
  typedef enum logic [1:0] {
    VISM_TGT_REQ = 2'b00,
    VISM_TGT_MASK = 2'b01,
    VISM_TGT_PRIO = 2'b10,
    VISM_TGT_NONE = 2'b11
  } vism_target_t;

  // Vector table address of the source at a flag position
  function automatic logic [15:0] vector_of(input logic [4:0] pos);
    logic [15:0] v;
    v = VEC_RESET;
    unique case (pos)
      5'h00: v = 16'h0004;
      5'h01: v = 16'h0006;
      5'h02: v = 16'h0008;
      5'h03: v = 16'h000A;
      5'h04: v = 16'h000C;
      5'h05: v = 16'h000E;
      5'h06: v = 16'h0010;
      5'h07: v = 16'h0012;
      5'h08: v = 16'h0014;
      5'h09: v = 16'h0016;
      5'h0A: v = 16'h0018;
      5'h0B: v = 16'h001A;
      5'h0C: v = 16'h001C;
      5'h0D: v = 16'h001E;
      5'h0E: v = 16'h0020;
      5'h0F: v = 16'h0022;
      5'h10: v = 16'h0024;
      5'h11: v = 16'h0026;
      5'h13: v = 16'h002A;
      5'h18: v = 16'h0034;
      default: v = VEC_RESET;
    endcase
    return v;
  endfunction

endpackage
`default_nettype wire

// File: logic/vism_pick.sv
`timescale 1ns/100ps
`default_nettype none
// Fixed-rank selector: high group first, then lowest flag position
module vism_pick (
  input wire logic [31:0] pending,
  input wire logic [31:0] high_group,
  output logic found,
  output logic [4:0] pos,
  output logic is_high
);

  // Requests of the high group that are pending
  logic [31:0] hi_pending;
  // Candidate set after group choice
  logic [31:0] pool;

  assign hi_pending = pending & high_group;

  // Group choice before rank choice
  always_comb begin
    pool = (|hi_pending) ? hi_pending : pending;
    is_high = |hi_pending;
  end

  // Descending scan, so the last hit is the lowest rank
  always_comb begin
    found = 1'h0;
    pos = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (pool[i]) begin
        found = 1'h1;
        pos = 5'(i);
      end
    end
  end

endmodule
`default_nettype wire

// File: logic/vism_source_map.sv
`timescale 1ns/100ps
`default_nettype none
// Maskable source gathering, flag groups and vector selection
module vism_source_map (
  input wire logic sys_clk,
  input wire logic rst,
  // External edge pins, asynchronous
  input wire logic [5:0] ext_pin,
  input wire logic capture_pin_a,
  input wire logic capture_pin_b,
  input wire logic reset_pin_n,
  // Edge enables for the external pins
  input wire logic [7:0] rising_edge_enable_reg,
  input wire logic [7:0] falling_edge_enable_reg,
  // Valid-edge choice for capture pins, bit 0 pin a, bit 1 pin b
  input wire logic [1:0] capture_rise_en,
  input wire logic [1:0] capture_fall_en,
  // Low-voltage detection and other reset causes
  input wire logic low_voltage_detect,
  input wire logic [7:0] low_voltage_control_reg,
  input wire logic power_on_clear,
  input wire logic watchdog_overflow,
  // Peripheral event pulses, same clock
  input wire logic async_serial_b_error_irq,
  input wire logic async_serial_b_receive_irq,
  input wire logic async_serial_b_transmit_irq,
  input wire logic clocked_serial_done_irq,
  input wire logic async_serial_a_transmit_irq,
  input wire logic timer_h_second_match_irq,
  input wire logic timer_h_first_match_irq,
  input wire logic timer8_a_match_irq,
  input wire logic timer16_compare_a,
  input wire logic timer16_compare_b,
  input wire logic timer16_capture_mode_a,
  input wire logic timer16_capture_mode_b,
  input wire logic conversion_end_irq,
  input wire logic async_serial_a_receive_irq,
  input wire logic timer8_b_match_irq,
  input wire logic timer8_b_carrier_mode,
  input wire logic carrier_output_signal,
  input wire logic two_wire_done_irq,
  // Software bit write into one flag byte
  input wire logic sw_wr_en,
  input wire logic [1:0] sw_wr_target,
  input wire logic [1:0] sw_wr_byte,
  input wire logic [7:0] sw_wr_mask,
  input wire logic [7:0] sw_wr_data,
  // Flag readback, four bytes each
  output logic [31:0] request_flag_rd,
  output logic [31:0] mask_flag_rd,
  output logic [31:0] priority_flag_rd,
  // Core side
  input wire logic interrupt_enable,
  input wire logic servicing_low,
  input wire logic servicing_high,
  input wire logic irq_ack,
  output logic irq_request,
  output logic [15:0] irq_vector,
  output logic irq_high_group,
  output logic standby_release,
  output logic reset_request,
  output logic lvi_reset_request
);

  // Raw pin lanes in synchroniser order
  logic [8:0] pin_raw;
  // Three-stage synchroniser and debounced level
  logic [8:0] pin_s1_q;
  logic [8:0] pin_s2_q;
  logic [8:0] pin_s3_q;
  logic [8:0] pin_lvl_q;
  // Qualified edges per lane
  logic [8:0] pin_rise;
  logic [8:0] pin_fall;
  // Per-lane edge enables
  logic [7:0] rise_en;
  logic [7:0] fall_en;
  // Valid edges on the eight edge lanes
  logic [7:0] pin_edge;

  // Hardware set pulses at flag positions
  logic [31:0] hw_set;
  // Flag groups
  logic [31:0] req_q;
  logic [31:0] req_d;
  logic [31:0] mask_q;
  logic [31:0] prio_q;
  // Software write lanes and values spread over the word
  logic [31:0] wr_sel;
  logic [31:0] wr_val;
  logic wr_req;
  logic wr_mask;
  logic wr_prio;
  // Acknowledge clear, one-hot at the presented source
  logic [31:0] ack_clr;

  // Selection
  logic [31:0] unmasked;
  logic [31:0] allowed;
  logic pick_found;
  logic [4:0] pick_pos;
  logic pick_high;

  // Presented request, all from flops
  logic irq_valid_q;
  logic [4:0] irq_pos_q;
  logic [15:0] irq_vector_q;
  logic irq_high_q;
  logic standby_q;
  logic reset_req_q;
  logic lvi_reset_q;

  // Low-voltage mode-select bit
  logic lvi_mode;

  assign pin_raw = {reset_pin_n, capture_pin_b, capture_pin_a, ext_pin};
  assign rise_en = {capture_rise_en, rising_edge_enable_reg[5:0]};
  assign fall_en = {capture_fall_en, falling_edge_enable_reg[5:0]};
  assign lvi_mode = low_voltage_control_reg[vism_pkg::LVI_MODE_BIT];

  // Pin synchronisers: a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < vism_pkg::PIN_N; gi++) begin : g_pin
      // Shift through three stages, idle level under reset
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          pin_s1_q[gi] <= vism_pkg::PIN_IDLE[gi];
          pin_s2_q[gi] <= vism_pkg::PIN_IDLE[gi];
          pin_s3_q[gi] <= vism_pkg::PIN_IDLE[gi];
        end else begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
          pin_s3_q[gi] <= pin_s2_q[gi];
        end
      end
      // Accepted level moves only on agreement
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          pin_lvl_q[gi] <= vism_pkg::PIN_IDLE[gi];
        end else if (pin_s2_q[gi] == pin_s3_q[gi]) begin
          pin_lvl_q[gi] <= pin_s3_q[gi];
        end
      end
      // Edge is one cycle, at the agreement that changes the level
      assign pin_rise[gi] = (pin_s2_q[gi] == pin_s3_q[gi]) &&
                            pin_s3_q[gi] && !pin_lvl_q[gi];
      assign pin_fall[gi] = (pin_s2_q[gi] == pin_s3_q[gi]) &&
                            !pin_s3_q[gi] && pin_lvl_q[gi];
    end
    // Edge lanes honour their own enables
    for (gi = 0; gi < 8; gi++) begin : g_edge
      assign pin_edge[gi] = (pin_rise[gi] && rise_en[gi]) ||
                            (pin_fall[gi] && fall_en[gi]);
    end
  endgenerate

  // Source events mapped to flag positions; rank equals position order
  always_comb begin
    hw_set = 32'h0000_0000;
    // Only an interrupt while mode-select is clear
    hw_set[vism_pkg::POS_LVI] = low_voltage_detect && !lvi_mode;
    for (int i = 0; i < 6; i++) begin
      hw_set[vism_pkg::POS_EXT0 + i] = pin_edge[i];
    end
    hw_set[vism_pkg::POS_SERB_ERR] = async_serial_b_error_irq;
    hw_set[vism_pkg::POS_SERB_RX] = async_serial_b_receive_irq;
    hw_set[vism_pkg::POS_SERB_TX] = async_serial_b_transmit_irq;
    // Either serial end sets the one shared flag
    hw_set[vism_pkg::POS_SHARED] = clocked_serial_done_irq ||
                                   async_serial_a_transmit_irq;
    hw_set[vism_pkg::POS_TMH_SECOND] = timer_h_second_match_irq;
    hw_set[vism_pkg::POS_TMH_FIRST] = timer_h_first_match_irq;
    hw_set[vism_pkg::POS_T8A] = timer8_a_match_irq;
    // Capture mode takes the opposite pin's valid edge
    hw_set[vism_pkg::POS_T16A] = timer16_capture_mode_a ?
      pin_edge[vism_pkg::PIN_CAP_B] : timer16_compare_a;
    hw_set[vism_pkg::POS_T16B] = timer16_capture_mode_b ?
      pin_edge[vism_pkg::PIN_CAP_A] : timer16_compare_b;
    hw_set[vism_pkg::POS_CONV] = conversion_end_irq;
    hw_set[vism_pkg::POS_SERA_RX] = async_serial_a_receive_irq;
    // Carrier mode times the request to the carrier output signal
    hw_set[vism_pkg::POS_T8B] = timer8_b_carrier_mode ?
      carrier_output_signal : timer8_b_match_irq;
    hw_set[vism_pkg::POS_TWO_WIRE] = two_wire_done_irq;
  end

  // Software write lanes: one byte, bit mask picks the bits touched
  always_comb begin
    wr_sel = 32'({24'h00_0000, sw_wr_mask} << {sw_wr_byte, 3'h0});
    wr_val = 32'({24'h00_0000, sw_wr_data} << {sw_wr_byte, 3'h0});
    wr_req = sw_wr_en &&
      (sw_wr_target == vism_pkg::VISM_TGT_REQ);
    wr_mask = sw_wr_en && (sw_wr_target == vism_pkg::VISM_TGT_MASK);
    wr_prio = sw_wr_en && (sw_wr_target == vism_pkg::VISM_TGT_PRIO);
  end

  // Clear only the source the core actually saw
  always_comb begin
    ack_clr = 32'h0000_0000;
    if (irq_ack && irq_valid_q) begin
      ack_clr[irq_pos_q] = 1'h1;
    end
  end

  // Request flags: a hardware set wins over any clear in the same cycle
  always_comb begin
    req_d = req_q;
    if (wr_req) begin
      req_d = (req_d & ~wr_sel) | (wr_val & wr_sel);
    end
    req_d = req_d & ~ack_clr;
    req_d = (req_d | hw_set) & vism_pkg::FLAG_MAP;
  end

  // Request flag group, cleared by reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      req_q <= vism_pkg::REQ_RESET;
    end else begin
      req_q <= req_d;
    end
  end

  // Mask flag group: every source starts disabled
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_q <= vism_pkg::MASK_RESET;
    end else if (wr_mask) begin
      mask_q <= (mask_q & ~wr_sel) | (wr_val & wr_sel);
    end
  end

  // Priority flag group: zero puts a source in the high group
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      prio_q <= vism_pkg::PRIO_RESET;
    end else if (wr_prio) begin
      prio_q <= (prio_q & ~wr_sel) | (wr_val & wr_sel);
    end
  end

  // Eligibility; an acked source is kept out so it is not offered twice
  always_comb begin
    // Shared serial sources live behind one mask bit
    unmasked = req_q & ~mask_q & vism_pkg::FLAG_MAP & ~ack_clr;
    allowed = 32'h0000_0000;
    if (interrupt_enable && !servicing_high) begin
      if (servicing_low) begin
        // Only the high group may nest into low-group service
        allowed = unmasked & ~prio_q;
      end else begin
        allowed = unmasked;
      end
    end
  end

  // Fixed-rank selector
  vism_pick u_pick (
    .pending(allowed),
    .high_group(~prio_q),
    .found(pick_found),
    .pos(pick_pos),
    .is_high(pick_high)
  );

  // Presented request registered each cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_valid_q <= 1'h0;
      irq_pos_q <= 5'h00;
      irq_vector_q <= vism_pkg::VEC_RESET;
      irq_high_q <= 1'h0;
    end else begin
      irq_valid_q <= pick_found;
      irq_pos_q <= pick_pos;
      irq_vector_q <= vism_pkg::vector_of(pick_pos);
      irq_high_q <= pick_high;
    end
  end

  // Wakeup from standby on any unmasked pending flag, ignores enable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      standby_q <= 1'h0;
    end else begin
      standby_q <= |unmasked;
    end
  end

  // Reset causes; low voltage joins them only with mode-select set
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reset_req_q <= 1'h0;
      lvi_reset_q <= 1'h0;
    end else begin
      lvi_reset_q <= low_voltage_detect && lvi_mode;
      reset_req_q <= !pin_lvl_q[vism_pkg::PIN_RESET] || power_on_clear ||
                     watchdog_overflow ||
                     (low_voltage_detect && lvi_mode);
    end
  end

  // Readback; request bytes show zero at unimplemented bits
  assign request_flag_rd = req_q;
  assign mask_flag_rd = mask_q;
  assign priority_flag_rd = prio_q;
  assign irq_request = irq_valid_q;
  assign irq_vector = irq_vector_q;
  assign irq_high_group = irq_high_q;
  assign standby_release = standby_q;
  assign reset_request = reset_req_q;
  assign lvi_reset_request = lvi_reset_q;

endmodule
`default_nettype wire

// File: verification/vism_source_map_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// Checks flag words and core-side outputs of the source map
module vism_source_map_asserts (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic low_voltage_detect,
  input wire logic [7:0] low_voltage_control_reg,
  input wire logic clocked_serial_done_irq,
  input wire logic async_serial_a_transmit_irq,
  input wire logic conversion_end_irq,
  input wire logic interrupt_enable,
  input wire logic servicing_low,
  input wire logic irq_ack,
  input wire logic [31:0] request_flag_rd,
  input wire logic [31:0] mask_flag_rd,
  input wire logic [31:0] priority_flag_rd,
  input wire logic irq_request,
  input wire logic [15:0] irq_vector,
  input wire logic irq_high_group,
  input wire logic lvi_reset_request
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Every source starts masked
  property p_mask_reset;
    $fell(rst) |-> mask_flag_rd == 32'hFFFF_FFFF;
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("mask flags not all ones after reset");
  // Detection in interrupt mode sets the flag
  property p_lvi_irq;
    low_voltage_detect && !low_voltage_control_reg[1] |=> request_flag_rd[0];
  endproperty
  a_lvi_irq: assert property (p_lvi_irq)
    else $error("low-voltage flag not set");
  // Reset mode: reset request, no new flag
  property p_lvi_reset;
    low_voltage_detect && low_voltage_control_reg[1] |=> lvi_reset_request
      && (request_flag_rd[0] -> $past(request_flag_rd[0]));
  endproperty
  a_lvi_reset: assert property (p_lvi_reset)
    else $error("low-voltage reset mode wrong");
  // Either serial end lands in the one shared flag
  property p_shared_set;
    clocked_serial_done_irq || async_serial_a_transmit_irq
      |=> request_flag_rd[10];
  endproperty
  a_shared_set: assert property (p_shared_set)
    else $error("shared serial flag not set");
  // Conversion end owns flag position 16
  property p_conv_set;
    conversion_end_irq |=> request_flag_rd[16];
  endproperty
  a_conv_set: assert property (p_conv_set)
    else $error("conversion flag not set");
  // Acknowledge clears the served flag unless set again
  property p_ack_clear;
    irq_ack && irq_request && irq_vector == 16'h0024 && !conversion_end_irq
      |=> !request_flag_rd[16];
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("acknowledged flag not cleared");
  // Nothing offered one cycle after interrupts were disabled
  property p_ie_gate;
    !$past(interrupt_enable) |-> !irq_request;
  endproperty
  a_ie_gate: assert property (p_ie_gate)
    else $error("request offered while disabled");
  // One mask bit gates the shared serial vector
  property p_shared_mask;
    irq_request && irq_vector == 16'h0018 |-> !$past(mask_flag_rd[10]);
  endproperty
  a_shared_mask: assert property (p_shared_mask)
    else $error("shared serial offered while masked");
  // One priority bit groups the shared serial vector
  property p_shared_prio;
    irq_request && irq_vector == 16'h0018
      |-> irq_high_group == !$past(priority_flag_rd[10]);
  endproperty
  a_shared_prio: assert property (p_shared_prio)
    else $error("shared serial group wrong");
  // Low group never nests into a low-group service
  property p_nest;
    irq_request && !irq_high_group |-> !$past(servicing_low);
  endproperty
  a_nest: assert property (p_nest)
    else $error("low request offered during low service");
endmodule
`default_nettype wire

// File: verification/vism_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// Core stand-in: enables, acknowledges after a wait, runs a routine
module vism_core_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic irq_request,
  input wire logic [15:0] irq_vector,
  input wire logic irq_high_group,
  input wire logic ie_cfg,
  input wire logic [3:0] ack_wait,
  output logic interrupt_enable,
  output logic servicing_low,
  output logic servicing_high,
  output logic irq_ack,
  output logic [15:0] last_vec,
  output logic [7:0] ack_count
);
  logic [3:0] wait_q; // Cycles the offer has stood
  logic [4:0] run_q; // Cycles left in the service routine
  // Outputs to the source map move after the falling edge only
  always @(negedge sys_clk) begin
    if (rst) begin
      interrupt_enable <= 1'h0;
      servicing_low <= 1'h0;
      servicing_high <= 1'h0;
      irq_ack <= 1'h0;
      wait_q <= 4'h0;
      run_q <= 5'h00;
    end else begin
      interrupt_enable <= ie_cfg;
      irq_ack <= 1'h0;
      wait_q <= (irq_request && !irq_ack) ? wait_q + 4'h1 : 4'h0;
      if (run_q != 5'h00) begin
        run_q <= run_q - 5'h01;
      end else begin
        servicing_low <= 1'h0;
        servicing_high <= 1'h0;
      end
      // One acknowledge per offer; gap lets the next offer settle
      if (irq_request && !irq_ack && wait_q >= ack_wait) begin
        irq_ack <= 1'h1;
        run_q <= 5'h14;
        if (irq_high_group) begin
          servicing_high <= 1'h1;
        end else begin
          servicing_low <= 1'h1;
        end
      end
    end
  end
  // Log what was taken at the acknowledging edge
  always @(posedge sys_clk) begin
    if (rst) begin
      ack_count <= 8'h00;
      last_vec <= 16'h0000;
    end else if (irq_ack && irq_request) begin
      ack_count <= ack_count + 8'h01;
      last_vec <= irq_vector;
    end
  end
endmodule
`default_nettype wire

// File: verification/tb_vism_source_map.sv
`timescale 1ns/100ps
`default_nettype none
module tb_vism_source_map;
  logic sys_clk = 1'h0; // 250 MHz system clock
  logic rst = 1'h1; // Held three cycles
  logic [17:0] ev = 18'h0_0000; // Event pulses, see dut hookup
  logic [5:0] ext_pin = 6'h00;
  logic capture_pin_a = 1'h0;
  logic capture_pin_b = 1'h0;
  logic reset_pin_n = 1'h1; // Reset pin idles high
  logic [7:0] rising_edge_enable_reg = 8'h00;
  logic [7:0] falling_edge_enable_reg = 8'h00;
  logic [1:0] capture_rise_en = 2'h0;
  logic timer16_capture_mode_a = 1'h0;
  logic timer16_capture_mode_b = 1'h0;
  logic timer8_b_carrier_mode = 1'h0;
  logic [7:0] low_voltage_control_reg = 8'h00;
  logic sw_wr_en = 1'h0;
  logic [1:0] sw_wr_target = 2'h3; // No target while idle
  logic [1:0] sw_wr_byte = 2'h0;
  logic [7:0] sw_wr_mask = 8'h00;
  logic [7:0] sw_wr_data = 8'h00;
  logic ie_cfg = 1'h1;
  logic [3:0] ack_wait = 4'h0; // Zero acknowledges at once
  logic interrupt_enable, servicing_low, servicing_high, irq_ack;
  logic irq_request, irq_high_group, standby_release;
  logic reset_request, lvi_reset_request;
  logic [15:0] irq_vector, last_vec;
  logic [31:0] request_flag_rd, mask_flag_rd, priority_flag_rd;
  logic [7:0] ack_count;
  logic [7:0] got = 8'h00; // Acknowledges already consumed
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  // Flag position per event; the last one is the carrier output
  int pos_t[16] = '{0, 7, 8, 9, 10, 10, 11, 12, 13, 14, 15, 16, 17, 19, 24,
    19};
  vism_source_map dut (
    .sys_clk, .rst, .ext_pin, .capture_pin_a, .capture_pin_b,
    .reset_pin_n, .rising_edge_enable_reg, .falling_edge_enable_reg,
    .capture_rise_en, .capture_fall_en(2'h0),
    .low_voltage_detect(ev[0]), .low_voltage_control_reg,
    .power_on_clear(ev[16]), .watchdog_overflow(ev[17]),
    .async_serial_b_error_irq(ev[1]), .async_serial_b_receive_irq(ev[2]),
    .async_serial_b_transmit_irq(ev[3]), .clocked_serial_done_irq(ev[4]),
    .async_serial_a_transmit_irq(ev[5]), .timer_h_second_match_irq(ev[6]),
    .timer_h_first_match_irq(ev[7]), .timer8_a_match_irq(ev[8]),
    .timer16_compare_a(ev[9]), .timer16_compare_b(ev[10]),
    .timer16_capture_mode_a, .timer16_capture_mode_b,
    .conversion_end_irq(ev[11]), .async_serial_a_receive_irq(ev[12]),
    .timer8_b_match_irq(ev[13]), .timer8_b_carrier_mode,
    .carrier_output_signal(ev[15]), .two_wire_done_irq(ev[14]),
    .sw_wr_en, .sw_wr_target, .sw_wr_byte, .sw_wr_mask, .sw_wr_data,
    .request_flag_rd, .mask_flag_rd, .priority_flag_rd,
    .interrupt_enable, .servicing_low, .servicing_high, .irq_ack,
    .irq_request, .irq_vector, .irq_high_group, .standby_release,
    .reset_request, .lvi_reset_request
  );
  vism_core_model core (
    .sys_clk, .rst, .irq_request, .irq_vector, .irq_high_group, .ie_cfg,
    .ack_wait, .interrupt_enable, .servicing_low, .servicing_high, .irq_ack,
    .last_vec, .ack_count
  );
  // Clock and hang guard
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      mismatches++;
      results;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  function automatic logic [31:0] flag(input int p);
    return {31'h0, request_flag_rd[p]};
  endfunction
  // Vector table address worked out from the flag position
  function automatic logic [15:0] exp_vec(input int p);
    if (p < 16) begin
      return 16'h0004 + 16'(2 * p);
    end
    case (p)
      16: return 16'h0024;
      17: return 16'h0026;
      19: return 16'h002A;
      default: return 16'h0034;
    endcase
  endfunction
  // Extra idle cycle so back-to-back writes never re-raise in one step
  task sw_write(input logic [1:0] t, input logic [1:0] b,
                input logic [7:0] m, input logic [7:0] d);
    sw_wr_target = t;
    sw_wr_byte = b;
    sw_wr_mask = m;
    sw_wr_data = d;
    sw_wr_en = 1'h1;
    step(1);
    sw_wr_en = 1'h0;
    step(1);
  endtask
  task pulse(input int i);
    ev[i] = 1'h1;
    step(1);
    ev[i] = 1'h0;
  endtask
  // Wait for the next acknowledge and compare its vector
  task take(input logic [15:0] want);
    for (int k = 0; k < 80 && ack_count === got; k++) begin
      step(1);
    end
    got = got + 8'h01;
    check({16'h0000, last_vec}, {16'h0000, want});
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    step(3);
    rst = 1'h0;
    step(1);
    check(mask_flag_rd, 32'hFFFF_FFFF);
    check(request_flag_rd, 32'h0000_0000);
    for (int b = 0; b < 4; b++) begin
      sw_write(2'h1, 2'(b), 8'hFF, 8'h00);
    end
    check(mask_flag_rd & vism_pkg::FLAG_MAP, 32'h0000_0000);
    $display("test reset done");
    // Every internal source alone, prompt acknowledge
    for (int i = 0; i < 16; i++) begin
      timer8_b_carrier_mode = (i == 15);
      pulse(i);
      check(flag(pos_t[i]), 32'h0000_0001);
      // Wakeup flop looks at the flag word, so it lags one cycle
      step(1);
      check({31'h0, standby_release}, 32'h0000_0001);
      take(exp_vec(pos_t[i]));
      step(1);
      check(flag(pos_t[i]), 32'h0000_0000);
    end
    $display("test vectors done");
    // Three at once, slow acknowledge: served by rank
    ack_wait = 4'h6;
    ev = 18'h0_4840;
    step(1);
    ev = 18'h0_0000;
    take(16'h001A);
    take(16'h0024);
    take(16'h0034);
    ack_wait = 4'h0;
    $display("test rank done");
    // Conversion to high group; nests into a low service
    sw_write(2'h2, 2'h2, 8'h01, 8'h00);
    pulse(6);
    take(16'h001A);
    pulse(11);
    take(16'h0024);
    check({31'h0, servicing_low}, 32'h0000_0001);
    step(45);
    ev = 18'h0_0840;
    step(1);
    ev = 18'h0_0000;
    take(16'h0024);
    take(16'h001A);
    $display("test group done");
    // Shared serial mask, then global enable
    // Let the low-group service run out, else nothing is offered anyway
    step(24);
    sw_write(2'h1, 2'h1, 8'h04, 8'h04);
    pulse(4);
    step(8);
    check(flag(10), 32'h0000_0001);
    check({24'h00_0000, ack_count}, {24'h00_0000, got});
    ie_cfg = 1'h0;
    sw_write(2'h1, 2'h1, 8'h04, 8'h00);
    step(6);
    check({24'h00_0000, ack_count}, {24'h00_0000, got});
    ie_cfg = 1'h1;
    take(16'h0018);
    $display("test mask done");
    // Low-voltage as a reset source, watchdog reset
    low_voltage_control_reg = 8'h02;
    pulse(0);
    check({31'h0, lvi_reset_request}, 32'h0000_0001);
    check(flag(0), 32'h0000_0000);
    low_voltage_control_reg = 8'h00;
    pulse(17);
    check({31'h0, reset_request}, 32'h0000_0001);
    pulse(16);
    check({31'h0, reset_request}, 32'h0000_0001);
    // Reset pin passes the synchroniser first, five cycles in all
    reset_pin_n = 1'h0;
    step(5);
    check({31'h0, reset_request}, 32'h0000_0001);
    reset_pin_n = 1'h1;
    $display("test reset sources done");
    // Capture on the opposite pin, then an external edge
    rising_edge_enable_reg = 8'h3F;
    capture_rise_en = 2'h3;
    timer16_capture_mode_a = 1'h1;
    timer16_capture_mode_b = 1'h1;
    capture_pin_b = 1'h1;
    take(16'h0020);
    capture_pin_a = 1'h1;
    take(16'h0022);
    ext_pin[0] = 1'h1;
    take(16'h0006);
    // Falling edge counts only once its own enable is set
    falling_edge_enable_reg = 8'h01;
    ext_pin[0] = 1'h0;
    take(16'h0006);
    $display("test pins done");
    results;
  end
endmodule
bind vism_source_map vism_source_map_asserts u_chk (
  .sys_clk, .rst, .low_voltage_detect, .low_voltage_control_reg,
  .clocked_serial_done_irq, .async_serial_a_transmit_irq,
  .conversion_end_irq, .interrupt_enable, .servicing_low, .irq_ack,
  .request_flag_rd, .mask_flag_rd, .priority_flag_rd, .irq_request,
  .irq_vector, .irq_high_group, .lvi_reset_request
);
`default_nettype wire
